// ==== core/burner_regs.vh ====
`ifndef BURNER_REGS_VH
`define BURNER_REGS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS  40
`define TICK_S         1
`define NS_PER_S       1000000000
`define KEY_HOLD_S     8'h01
`define IGNITE_LIMIT_S 8'h3C

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CTRL_ADDR      8'h00
`define PURGE_ADDR     8'h04
`define STATUS_ADDR    8'h08

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_RELIGHT   0
`define CTRL_CLEAR     1
`define PURGE_RST      8'h1E

// ----------------------------------------
// status fields
// ----------------------------------------
`define STAT_STATE_LO  0
`define STAT_CODE_LO   4
`define STAT_IGNITE    7
`define STAT_SHUTOFF   8
`define STAT_PILOT     9
`define STAT_ALARM     10
`define STAT_FLAME     11
`define STAT_SECS_LO   16

`endif

// ==== core/manual_burner_sequencer.v ====
`timescale 1ns/1ps
`include "burner_regs.vh"

module manual_burner_sequencer #(
  // cycles per one-second tick; shorten in simulation
  parameter SEC_CYCLES = `TICK_S * (`NS_PER_S / `CLK_PERIOD_NS)
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        stop_key,
  input  wire        confirm_key,
  input  wire        arrow_key,
  input  wire        closure_proof_input,
  input  wire        flame_detect,
  input  wire [2:0]  process_demand,
  output reg         emergency_shutoff_valve,
  output reg         pilot_valve,
  output reg         ignition,
  output reg  [2:0]  process_valve,
  output reg         alarm_out
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] S_STOPPED = 3'h0;
  localparam [2:0] S_STARTUP = 3'h1;
  localparam [2:0] S_PURGE   = 3'h2;
  localparam [2:0] S_IGNITE  = 3'h3;
  localparam [2:0] S_IDLE    = 3'h4;
  localparam [2:0] S_HOLD    = 3'h5;
  localparam [2:0] S_ACTIVE  = 3'h6;
  localparam [2:0] S_FAULT   = 3'h7;

  // last cycle of a one-second tick; the full count is cut to
  // the 25-bit tick counter, which holds one second at 25 MHz
  localparam [31:0] SEC_FULL = SEC_CYCLES - 1;
  localparam [24:0] SEC_LAST = SEC_FULL[24:0];

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [7:0]  sync1;        // first stage, read only by sync2
  reg  [7:0]  sync2;        // pins in hclk domain
  reg         confirm_q;    // previous confirm level
  reg  [2:0]  state;        // sequencer state
  reg  [2:0]  next_state;
  reg  [2:0]  code;         // one bit per running process
  reg  [2:0]  next_code;
  reg  [24:0] cyc;          // cycles within current second
  reg  [7:0]  secs;         // whole seconds in state
  reg  [7:0]  purge_time;   // purge delay, seconds
  reg         relight_opt;  // stored only, no effect here
  reg         alarm_clr;    // one-cycle clear pulse
  reg         wr_pend;      // write data phase pending
  reg         rd_pend;      // read data phase pending
  reg  [7:0]  bus_addr;     // latched byte address

  wire        stop_s    = sync2[0];
  wire        confirm_s = sync2[1];
  wire        arrow_s   = sync2[2];
  wire        closure_s = sync2[3];
  wire        flame_s   = sync2[4];
  wire [2:0]  demand_s  = sync2[7:5];
  wire        both_held = confirm_s & arrow_s;
  wire        conf_rise = confirm_s & ~confirm_q;
  wire        take      = hsel & hready & htrans[1];

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  function [31:0] reg_read;
    input [7:0] a;
    begin
      reg_read = 32'h0000_0000;
      case (a)
        `CTRL_ADDR: begin
          reg_read[`CTRL_RELIGHT] = relight_opt;
        end
        `PURGE_ADDR: begin
          reg_read[7:0] = purge_time;
        end
        `STATUS_ADDR: begin
          reg_read[`STAT_STATE_LO +: 3] = state;
          reg_read[`STAT_CODE_LO +: 3]  = code;
          reg_read[`STAT_IGNITE]        = ignition;
          reg_read[`STAT_SHUTOFF]       = emergency_shutoff_valve;
          reg_read[`STAT_PILOT]         = pilot_valve;
          reg_read[`STAT_ALARM]         = alarm_out;
          reg_read[`STAT_FLAME]         = flame_s;
          reg_read[`STAT_SECS_LO +: 8]  = secs;
        end
        default: begin
          reg_read = 32'h0000_0000;
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // keys and field inputs are asynchronous to hclk
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1     <= 8'h00;
      sync2     <= 8'h00;
      confirm_q <= 1'b0;
    end else begin
      sync1     <= {process_demand, flame_detect, closure_proof_input,
                    arrow_key, confirm_key, stop_key};
      sync2     <= sync1;
      confirm_q <= confirm_s;
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  // reads take one wait state so a read right after
  // a write always sees the written value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      bus_addr    <= 8'h00;
      purge_time  <= `PURGE_RST;
      relight_opt <= 1'b0;
      alarm_clr   <= 1'b0;
    end else begin
      hresp     <= 1'b0;
      alarm_clr <= 1'b0;
      // write data phase
      if (wr_pend) begin
        case (bus_addr)
          `CTRL_ADDR: begin
            relight_opt <= hwdata[`CTRL_RELIGHT];
            alarm_clr   <= hwdata[`CTRL_CLEAR];
          end
          `PURGE_ADDR: begin
            purge_time <= hwdata[7:0];
          end
          default: begin
            // read-only or unmapped: ignored
          end
        endcase
      end
      // read data phase, second cycle ends it
      if (rd_pend) begin
        hrdata    <= reg_read(bus_addr);
        hreadyout <= 1'b1;
        rd_pend   <= 1'b0;
        wr_pend   <= 1'b0;
      end else if (take) begin
        bus_addr  <= haddr[7:0];
        wr_pend   <= hwrite;
        rd_pend   <= ~hwrite;
        hreadyout <= hwrite;
      end else begin
        wr_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_code  = code;
    case (state)
      S_STOPPED: begin
        if (!stop_s && both_held && secs >= `KEY_HOLD_S) begin
          next_state = S_STARTUP;
        end
      end
      S_STARTUP: begin
        if (closure_s) begin
          next_state = S_FAULT;
        end else if (both_held) begin
          next_state = S_PURGE;
        end else begin
          next_state = S_STOPPED;
        end
      end
      S_PURGE: begin
        if (!both_held) begin
          next_state = S_STOPPED;
        end else if (secs >= purge_time) begin
          next_state = S_IGNITE;
        end
      end
      S_IGNITE: begin
        if (!both_held) begin
          next_state = S_STOPPED;
        end else if (flame_s) begin
          next_state = S_IDLE;
        end else if (secs >= `IGNITE_LIMIT_S) begin
          next_state = S_STOPPED;
        end
      end
      S_IDLE: begin
        if (!flame_s) begin
          next_state = S_STOPPED;
        end else if (conf_rise) begin
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!flame_s) begin
          next_state = S_STOPPED;
        end else if (demand_s != 3'h0) begin
          next_state = S_ACTIVE;
          next_code  = demand_s;
        end
      end
      S_ACTIVE: begin
        if (!flame_s) begin
          next_state = S_STOPPED;
        end else if (demand_s == 3'h0) begin
          next_state = S_HOLD;
        end else begin
          next_code = demand_s;
        end
      end
      S_FAULT: begin
        if (alarm_clr) begin
          next_state = S_STOPPED;
        end
      end
      default: begin
        next_state = S_STOPPED;
      end
    endcase
    // stop wins outside the alarm state
    if (stop_s && state != S_FAULT) begin
      next_state = S_STOPPED;
    end
    if (next_state != S_ACTIVE) begin
      next_code = 3'h0;
    end
  end

  // ----------------------------------------
  // state, timer and outputs
  // ----------------------------------------
  // outputs follow next_state so they change with state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                   <= S_STOPPED;
      code                    <= 3'h0;
      cyc                     <= 25'h0000000;
      secs                    <= 8'h00;
      emergency_shutoff_valve <= 1'b0;
      pilot_valve             <= 1'b0;
      ignition                <= 1'b0;
      process_valve           <= 3'h0;
      alarm_out               <= 1'b1;
    end else begin
      state <= next_state;
      code  <= next_code;
      // timer restarts on every state change and
      // while stopped with the start keys not both held
      if (next_state != state ||
          (state == S_STOPPED && !both_held)) begin
        cyc  <= 25'h0000000;
        secs <= 8'h00;
      end else if (cyc == SEC_LAST) begin
        cyc <= 25'h0000000;
        if (secs != 8'hFF) begin
          secs <= secs + 8'h01;
        end
      end else begin
        cyc <= cyc + 25'h0000001;
      end
      ignition <= (next_state == S_IGNITE);
      emergency_shutoff_valve <= (next_state == S_IGNITE) ||
                                 (next_state == S_IDLE) ||
                                 (next_state == S_HOLD) ||
                                 (next_state == S_ACTIVE);
      pilot_valve <= (next_state == S_IGNITE) ||
                     (next_state == S_IDLE) ||
                     (next_state == S_HOLD) ||
                     (next_state == S_ACTIVE);
      // each code bit drives its valve
      process_valve <= next_code;
      alarm_out <= (next_state == S_STOPPED) ||
                   (next_state == S_FAULT);
    end
  end

endmodule

// ==== sim/burner_asserts.sv ====
`timescale 1ns/1ps
module burner_asserts #(
  parameter SEC_CYCLES = 10
) (
  input wire       hclk,
  input wire       hresetn,
  input wire       hreadyout,
  input wire       hresp,
  input wire       stop_key,
  input wire       flame_detect,
  input wire [2:0] process_demand,
  input wire       emergency_shutoff_valve,
  input wire       pilot_valve,
  input wire       ignition,
  input wire [2:0] process_valve,
  input wire       alarm_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // length of the current ignite run in cycles
  reg [31:0] ign_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ign_cnt <= 32'h0;
    else ign_cnt <= ignition ? ign_cnt + 32'h1 : 32'h0;
  end
  stopped_closed_a:
    assert property (alarm_out |-> !pilot_valve && !ignition && process_valve == 3'h0)
    else $error("valve open while alarm is on");
  ignite_valves_a:
    assert property (ignition |-> emergency_shutoff_valve && pilot_valve && !process_valve)
    else $error("igniting without gas path");
  ignite_limit_a:
    assert property (ign_cnt <= 60 * SEC_CYCLES + 4) else $error("ignite ran too long");
  stop_forces_a:
    assert property (stop_key [*5] |-> !pilot_valve && process_valve == 3'h0)
    else $error("stop key did not close valves");
  flame_loss_a:
    assert property (!flame_detect [*5] |-> !(pilot_valve && !ignition))
    else $error("pilot open without flame");
  no_relight_a:
    assert property ($fell(pilot_valve) |-> !ignition [*8]) else $error("automatic relight");
  demand_match_a:
    assert property ((process_valve & ~($past(process_demand, 2) | $past(process_demand, 3)
      | $past(process_demand, 4))) == 3'h0) else $error("valve open without demand");
  shutoff_pilot_a:
    assert property (emergency_shutoff_valve == pilot_valve) else $error("shutoff and pilot differ");
  read_wait_a:
    assert property (!hreadyout |=> hreadyout) else $error("wait state longer than one");
  okay_resp_a:
    assert property (hresp == 1'b0) else $error("response not okay");
endmodule

bind manual_burner_sequencer burner_asserts #(.SEC_CYCLES(SEC_CYCLES)) i_burner_asserts (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .stop_key(stop_key), .flame_detect(flame_detect), .process_demand(process_demand),
  .emergency_shutoff_valve(emergency_shutoff_valve), .pilot_valve(pilot_valve),
  .ignition(ignition), .process_valve(process_valve), .alarm_out(alarm_out));

// ==== sim/flame_field_model.sv ====
`timescale 1ns/1ps
module flame_field_model (
  input  wire hclk,
  input  wire flame_enable,
  input  wire pilot_valve,
  input  wire ignition,
  output reg  flame_detect
);
  // flame needs gas and a spark to start, then burns on gas alone;
  // the bench blows it out by dropping flame_enable
  initial flame_detect = 1'b0;
  always @(posedge hclk) begin
    flame_detect <= pilot_valve && flame_enable && (flame_detect || ignition);
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "burner_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, stop_key, confirm_key, arrow_key;
  logic        closure_proof_input, flame_detect, flame_en, esv, pilot_valve, ignition, alarm_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  process_demand, process_valve;
  int          err_total, n_compared, n;
  manual_burner_sequencer #(.SEC_CYCLES(10)) i_manual_burner_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .stop_key(stop_key), .confirm_key(confirm_key),
    .arrow_key(arrow_key), .closure_proof_input(closure_proof_input),
    .flame_detect(flame_detect), .process_demand(process_demand),
    .emergency_shutoff_valve(esv), .pilot_valve(pilot_valve), .ignition(ignition),
    .process_valve(process_valve), .alarm_out(alarm_out));
  flame_field_model i_flame_field_model (.hclk(hclk), .flame_enable(flame_en),
    .pilot_valve(pilot_valve), .ignition(ignition), .flame_detect(flame_detect));
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one single transfer; hready is sampled at each rising edge, hrdata once at the end
  task automatic bus(input [7:0] a, input w, input [31:0] wd, output [31:0] d);
    int k;
    k = 0;
    d = 32'h0;
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do begin @(posedge hclk); k++; end while (!hready && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge hclk); k++; end while (!hready && k < 50);
    d = hrdata;
    if (k >= 50) begin err_total++; complete_run; end
  endtask
  task automatic wait_state(input [2:0] s);
    for (n = 0; n < 400; n++) begin
      bus(`STATUS_ADDR, 1'b0, 32'h0, rd);
      if (rd[2:0] === s) break;
    end
    `CHK("state", s, rd[2:0])
    if (rd[2:0] !== s) complete_run;
  endtask
  task automatic outs(input [6:0] e);
    @(negedge hclk);
    `CHK("outputs", e, {alarm_out, esv, pilot_valve, ignition, process_valve})
    @(posedge hclk);
  endtask
  task automatic keys(input v);
    confirm_key <= v; arrow_key <= v;
  endtask
  task automatic t_reset;
    wait_state(3'h0);
    outs(7'h40);
    bus(`PURGE_ADDR, 1'b0, 32'h0, rd);
    `CHK("purge", {24'h0, `PURGE_RST}, rd)
    bus(8'h40, 1'b0, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    bus(`CTRL_ADDR, 1'b1, 32'h1, rd); // relight option set, must change nothing
    $display("test reset done");
  endtask
  task automatic t_fault;
    closure_proof_input <= 1'b1; keys(1'b1);
    wait_state(3'h7);
    outs(7'h40);
    stop_key <= 1'b1; keys(1'b0); closure_proof_input <= 1'b0;
    repeat (8) @(posedge hclk);
    wait_state(3'h7);
    stop_key <= 1'b0;
    bus(`CTRL_ADDR, 1'b1, 32'h2, rd);
    wait_state(3'h0);
    $display("test closure fault done");
  endtask
  task automatic t_release;
    bus(`PURGE_ADDR, 1'b1, 32'h5, rd);
    keys(1'b1);
    wait_state(3'h2);
    keys(1'b0);
    repeat (6) @(posedge hclk);
    wait_state(3'h0);
    outs(7'h40);
    $display("test purge release done");
  endtask
  task automatic t_timeout;
    bus(`PURGE_ADDR, 1'b1, 32'h1, rd);
    flame_en <= 1'b0; keys(1'b1);
    wait_state(3'h3);
    outs(7'h38);
    for (n = 0; n < 700 && ignition !== 1'b0; n++) @(negedge hclk);
    `CHK("ignite_cycles", 1'b1, n > 585 && n < 602)
    @(posedge hclk);
    keys(1'b0);
    wait_state(3'h0);
    $display("test ignite timeout done");
  endtask
  // light the pilot by hand and confirm process start
  task automatic light;
    flame_en <= 1'b1; keys(1'b1);
    wait_state(3'h4);
    repeat (10) @(posedge hclk);
    wait_state(3'h4);
    keys(1'b0);
    repeat (4) @(posedge hclk);
    confirm_key <= 1'b1;
    repeat (4) @(posedge hclk);
    confirm_key <= 1'b0;
    wait_state(3'h5);
    repeat (10) @(posedge hclk);
    wait_state(3'h5);
  endtask
  task automatic t_run;
    logic [2:0] seq [8] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h5, 3'h2, 3'h0};
    light;
    foreach (seq[i]) begin
      process_demand <= seq[i];
      repeat (6) @(posedge hclk);
      bus(`STATUS_ADDR, 1'b0, 32'h0, rd);
      `CHK("code", seq[i], rd[6:4])
      `CHK("valves", seq[i], process_valve)
    end
    wait_state(3'h5);
    process_demand <= 3'h2;
    wait_state(3'h6);
    bus(`CTRL_ADDR, 1'b1, 32'h1, rd); // relight option on, must stay unused
    flame_en <= 1'b0;
    wait_state(3'h0);
    repeat (30) @(posedge hclk);
    outs(7'h40);
    bus(`CTRL_ADDR, 1'b0, 32'h0, rd);
    `CHK("relight", 32'h1, rd)
    process_demand <= 3'h0;
    $display("test active run done");
  endtask
  task automatic t_stop;
    light;
    process_demand <= 3'h1;
    wait_state(3'h6);
    stop_key <= 1'b1;
    repeat (6) @(posedge hclk);
    outs(7'h40);
    stop_key <= 1'b0; process_demand <= 3'h0;
    $display("test stop key done");
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, stop_key, confirm_key, arrow_key} = 6'h0;
    {closure_proof_input, flame_en, err_total, n_compared} = 0;
    {haddr, hwdata, htrans, process_demand} = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_fault;
    t_release;
    t_timeout;
    t_run;
    t_stop;
    complete_run;
  end
endmodule
